// File: umfl_defines.svh
`ifndef UMFL_DEFINES_SVH
`define UMFL_DEFINES_SVH

// Receive and transmit FIFO depth
`define UMFL_FIFO_DEPTH 16
`define UMFL_DATA_W 8
`define UMFL_ERR_W 3
`define UMFL_ENTRY_W 11
`define UMFL_TMR_W 8

// Trigger levels for selector codes 0..3
`define UMFL_TRIG_0 5'h01
`define UMFL_TRIG_1 5'h04
`define UMFL_TRIG_2 5'h08
`define UMFL_TRIG_3 5'h0E

// Host reads allowed after a paced timeout
`define UMFL_RX_READ_LIMIT 3'h4

// Line status bit positions
`define UMFL_LSR_DR 0
`define UMFL_LSR_OE 1
`define UMFL_LSR_PE 2
`define UMFL_LSR_BI 4
`define UMFL_LSR_HOLDING_EMPTY_FLAG 5
`define UMFL_LSR_TRANSMITTER_EMPTY_FLAG 6
`define UMFL_LSR_FERR 7

// Host strobe slots in the synchroniser
`define UMFL_HS_N 5
`define UMFL_HS_RXRD 0
`define UMFL_HS_LSRRD 1
`define UMFL_HS_IIRRD 2
`define UMFL_HS_TXWR 3
`define UMFL_HS_LCRWR 4

`endif

// File: umfl_pkg.sv
package umfl_pkg;

typedef logic [7:0] umfl_byte_t;

typedef struct packed {
    logic [4:0] hsMeta;
    logic [4:0] hsSync;
    logic [4:0] hsPrev;
    logic [2:0] shadow;
    logic [2:0] errAcc;
    logic overrun;
    logic rxToIrq;
    logic rxTrigIrq;
    logic toArmed;
    logic [2:0] readsAfterTo;
    logic drBlock;
    logic [4:0] paceOwed;
    logic rxEmptyPrev;
    logic txEmptyPrev;
    logic hostTxEmptyIrq;
    logic mpuRxEmptyIrq;
    logic mpuTxTrigIrq;
    logic mpuTxToIrq;
    logic tsrFull;
    umfl_byte_t tsrData;
    logic hostTemt;
    logic mpuTemtWr;
    logic mpuTemt;
    logic mpuIrq;
    logic dmaReq;
    umfl_byte_t lcrMaster;
    umfl_byte_t lcrSlave;
    logic lcrPend;
    logic lcrWrDuringRd;
    logic lcrRdPrev;
    umfl_byte_t line_status_reg;
    umfl_byte_t rxData;
} umfl_state_s;

endpackage

// File: umfl_fifo.sv
`timescale 1ns/1ps
module umfl_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16,
    localparam int AW = $clog2(DEPTH),
    localparam int CW = AW + 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic flush,
    input wire logic push,
    input wire logic [W-1:0] pushData,
    input wire logic pushFlag,
    input wire logic pop,
    output logic [W-1:0] headData,
    output logic headFlag,
    output logic empty,
    output logic full,
    output logic [CW-1:0] count,
    output logic flagged
);
    typedef struct packed {
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [CW-1:0] cnt;
        logic [CW-1:0] flagCnt;
        logic [DEPTH-1:0] flagBits;
    } umfl_fifo_s;

    umfl_fifo_s st_r;
    umfl_fifo_s st_nxt;
    logic [W-1:0] mem [DEPTH];
    logic doPush;
    logic doPop;

    // Pointers wrap naturally, so DEPTH must be a power of two
    assign empty = (st_r.cnt == '0);
    assign full = (st_r.cnt == CW'(DEPTH));
    assign count = st_r.cnt;
    assign flagged = (st_r.flagCnt != '0);
    assign headData = mem[st_r.rd];
    assign headFlag = st_r.flagBits[st_r.rd];
    assign doPush = push && !full;
    assign doPop = pop && !empty;

    // Pointer arithmetic from the registered pointers only
    always_comb begin
        st_nxt = st_r;
        if (doPush) begin
            st_nxt.wr = st_r.wr + AW'(1);
            st_nxt.flagBits[st_r.wr] = pushFlag;
        end
        if (doPop) begin
            st_nxt.rd = st_r.rd + AW'(1);
        end
        st_nxt.cnt = st_r.cnt + CW'(doPush) - CW'(doPop);
        st_nxt.flagCnt = st_r.flagCnt + CW'(doPush && pushFlag)
            - CW'(doPop && headFlag);
        if (flush) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Storage needs no reset; only the pointers qualify it
    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[st_r.wr] <= pushData;
        end
    end
endmodule // umfl_fifo

// File: umfl_timer.sv
`timescale 1ns/1ps
module umfl_timer #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic tick,
    input wire logic clear,
    input wire logic load,
    input wire logic [W-1:0] reload,
    output logic expired
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } umfl_tmr_s;

    umfl_tmr_s st_r;
    umfl_tmr_s st_nxt;

    assign expired = (st_r.cnt == '0);

    // Clear beats load, load beats counting
    always_comb begin
        st_nxt = st_r;
        if (clear) begin
            st_nxt.cnt = '0;
        end else if (load) begin
            st_nxt.cnt = reload;
        end else if (tick && !expired) begin
            st_nxt.cnt = st_r.cnt - W'(1);
        end
    end

    // Reset leaves the timer in its timed-out state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // umfl_timer

// File: umfl_line_status.sv
`timescale 1ns/1ps
`include "umfl_defines.svh"
module umfl_line_status #(
    parameter int DEPTH = `UMFL_FIFO_DEPTH,
    localparam int CW = $clog2(DEPTH) + 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic serialTick,
    input wire logic fifoMode,
    input wire logic dblBufEn,
    input wire logic charDelayEn,
    input wire logic rxToEnhEn,
    input wire logic fifoReset,
    input wire logic [1:0] rxTrigSel,
    input wire logic [1:0] txTrigSel,
    input wire logic [7:0] rxToReload,
    input wire logic [7:0] txToReload,
    input wire logic [7:0] charDelayReload,
    input wire logic mpuRxWr,
    input wire logic [7:0] mpuRxData,
    input wire logic mpuLsrWr,
    input wire logic [7:0] mpuLsrData,
    input wire logic mpuTxRd,
    input wire logic mpuPendRd,
    input wire logic mpuLcrRd,
    input wire logic hostRxRd,
    input wire logic hostLsrRd,
    input wire logic hostIirRd,
    input wire logic hostTxWr,
    input wire logic [7:0] hostTxData,
    input wire logic hostLcrWr,
    input wire logic [7:0] hostLcrData,
    output logic [7:0] lineStatus,
    output logic [7:0] rxData,
    output logic hostRxTrigIrq,
    output logic hostRxTimeoutIrq,
    output logic hostTxEmptyIrq,
    output logic mpuRxEmptyIrq,
    output logic mpuTxTrigIrq,
    output logic mpuTxTimeoutIrq,
    output logic mpuInterruptRequest,
    output logic mpuDmaRequest,
    output logic [7:0] mpuTxData,
    output logic mpuTemt,
    output logic [7:0] lcrValue,
    output logic lcrPending
);
    umfl_pkg::umfl_state_s st_r;
    umfl_pkg::umfl_state_s st_nxt;
    // Empty-edge history starts at empty, so leaving reset raises no interrupt
    localparam umfl_pkg::umfl_state_s resetState = '{rxEmptyPrev: 1'b1, txEmptyPrev: 1'b1,
        default: '0};

    logic [`UMFL_HS_N-1:0] hsEv;
    logic rxRdEv, lsrRdEv, iirRdEv, txWrEv, lcrWrEv;
    logic [`UMFL_ENTRY_W-1:0] rxHead;
    logic rxHeadFlag, rxEmpty, rxFull, rxFlagged;
    logic [CW-1:0] rxCount;
    logic [`UMFL_DATA_W-1:0] txHead;
    logic txEmpty, txFull;
    logic [CW-1:0] txCount;
    logic rxPush, rxPop, txPush, tsrLoad, tsrFree;
    logic rxAccess, txAccess, rxToExp, txToExp, delayExp, paceExp;
    logic paceIdleLoad, paceDone, paceLoad;
    logic [`UMFL_ERR_W-1:0] rxEntryErr, headErr;
    logic [CW-1:0] rxTrig, txTrig;
    logic rxBelow, temtRise;

    function automatic logic [CW-1:0] trigLevel(input logic [1:0] sel);
        unique case (sel)
            2'h0: trigLevel = CW'(`UMFL_TRIG_0);
            2'h1: trigLevel = CW'(`UMFL_TRIG_1);
            2'h2: trigLevel = CW'(`UMFL_TRIG_2);
            2'h3: trigLevel = CW'(`UMFL_TRIG_3);
        endcase
    endfunction

    // Host strobe edges seen only past the second synchroniser stage
    assign hsEv = st_r.hsSync & ~st_r.hsPrev;
    assign rxRdEv = hsEv[`UMFL_HS_RXRD];
    assign lsrRdEv = hsEv[`UMFL_HS_LSRRD];
    assign iirRdEv = hsEv[`UMFL_HS_IIRRD];
    assign txWrEv = hsEv[`UMFL_HS_TXWR];
    assign lcrWrEv = hsEv[`UMFL_HS_LCRWR];

    // Receive path: shadow errors ride along with the byte
    assign rxEntryErr = fifoMode ? st_r.shadow : '0;
    assign rxPush = mpuRxWr;
    // Outside FIFO mode a second write replaces the single byte
    assign rxPop = rxRdEv || (!fifoMode && mpuRxWr && !rxEmpty);
    assign headErr = rxHead[`UMFL_ENTRY_W-1:`UMFL_DATA_W];
    assign rxAccess = mpuRxWr || rxRdEv;
    assign rxTrig = trigLevel(rxTrigSel);
    assign rxBelow = rxCount < rxTrig;

    umfl_fifo #(.W(`UMFL_ENTRY_W), .DEPTH(DEPTH)) rxFifo (
        .clk(clk),
        .reset_n(reset_n),
        .flush(fifoReset),
        .push(rxPush),
        .pushData({rxEntryErr, mpuRxData}),
        .pushFlag(|rxEntryErr),
        .pop(rxPop),
        .headData(rxHead),
        .headFlag(rxHeadFlag),
        .empty(rxEmpty),
        .full(rxFull),
        .count(rxCount),
        .flagged(rxFlagged)
    );

    // Transmit path: host fills, shift buffer takes the head
    assign txPush = txWrEv;
    assign txAccess = txWrEv || mpuTxRd;
    assign txTrig = trigLevel(txTrigSel);
    assign tsrFree = !st_r.tsrFull || mpuTxRd;
    assign tsrLoad = tsrFree && !txEmpty && (!charDelayEn || delayExp);

    umfl_fifo #(.W(`UMFL_DATA_W), .DEPTH(DEPTH)) txFifo (
        .clk(clk),
        .reset_n(reset_n),
        .flush(fifoReset),
        .push(txPush),
        .pushData(hostTxData),
        .pushFlag(1'b0),
        .pop(tsrLoad),
        .headData(txHead),
        .headFlag(),
        .empty(txEmpty),
        .full(txFull),
        .count(txCount),
        .flagged()
    );

    // Character delay restarts on each transfer to the shift buffer
    assign temtRise = st_nxt.hostTemt && !st_r.hostTemt;

    umfl_timer #(.W(`UMFL_TMR_W)) delayTimer (
        .clk(clk),
        .reset_n(reset_n),
        .tick(serialTick),
        .clear(fifoReset || temtRise),
        .load(tsrLoad),
        .reload(charDelayReload),
        .expired(delayExp)
    );

    // Per-byte pacing of the receive FIFO for the enhancement
    assign paceIdleLoad = rxToEnhEn && rxPush && st_r.paceOwed == '0;
    assign paceDone = st_r.paceOwed != '0 && paceExp;
    assign paceLoad = paceIdleLoad
        || (paceDone && (st_r.paceOwed > 5'h01 || rxPush));

    umfl_timer #(.W(`UMFL_TMR_W)) paceTimer (
        .clk(clk),
        .reset_n(reset_n),
        .tick(serialTick),
        .clear(fifoReset),
        .load(paceLoad),
        .reload(charDelayReload),
        .expired(paceExp)
    );

    // Timeout only counts once every byte has been paced
    umfl_timer #(.W(`UMFL_TMR_W)) rxToTimer (
        .clk(clk),
        .reset_n(reset_n),
        .tick(serialTick && (!rxToEnhEn || st_r.paceOwed == '0)),
        .clear(fifoReset),
        .load(rxAccess),
        .reload(rxToReload),
        .expired(rxToExp)
    );

    umfl_timer #(.W(`UMFL_TMR_W)) txToTimer (
        .clk(clk),
        .reset_n(reset_n),
        .tick(serialTick),
        .clear(fifoReset),
        .load(txAccess),
        .reload(txToReload),
        .expired(txToExp)
    );

    // Next state for every flag; sets beat clears except for the timeout flags, the read budget and FIFO reset
    always_comb begin
        st_nxt = st_r;
        st_nxt.hsMeta = {hostLcrWr, hostTxWr, hostIirRd, hostLsrRd, hostRxRd};
        st_nxt.hsSync = st_r.hsMeta;
        st_nxt.hsPrev = st_r.hsSync;

        // Shadow bits cleared once copied, rewritten by the MPU
        if (rxPush) begin
            st_nxt.shadow = '0;
        end
        if (mpuLsrWr && fifoMode) begin
            st_nxt.shadow = st_nxt.shadow | mpuLsrData[`UMFL_LSR_BI:`UMFL_LSR_PE];
        end

        // Host error bits: cleared by status read, then re-set
        if (lsrRdEv) begin
            st_nxt.errAcc = '0;
            st_nxt.overrun = 1'b0;
        end
        if (rxRdEv && !rxEmpty) begin
            st_nxt.errAcc = st_nxt.errAcc | headErr;
        end
        if (mpuLsrWr && !fifoMode) begin
            st_nxt.errAcc = st_nxt.errAcc | mpuLsrData[`UMFL_LSR_BI:`UMFL_LSR_PE];
        end
        if (mpuRxWr && (fifoMode ? rxFull : !rxEmpty)) begin
            st_nxt.overrun = 1'b1;
        end

        // Pacing debt: one per byte written, one per expiry
        st_nxt.paceOwed = st_r.paceOwed + 5'(rxToEnhEn && rxPush) - 5'(paceDone);
        if (fifoReset || !rxToEnhEn) begin
            st_nxt.paceOwed = '0;
        end

        // Receive trigger and timeout interrupts
        st_nxt.rxTrigIrq = fifoMode && !rxBelow;
        if (rxAccess || !rxBelow || rxEmpty) begin
            st_nxt.rxToIrq = 1'b0;
        end else if (fifoMode && rxToExp) begin
            st_nxt.rxToIrq = 1'b1;
        end

        // Read budget after a paced timeout, reopened by new data
        if (rxToEnhEn && st_nxt.rxToIrq && !st_r.rxToIrq) begin
            st_nxt.toArmed = 1'b1;
        end
        if (st_r.toArmed && rxRdEv && !st_r.drBlock) begin
            st_nxt.readsAfterTo = st_r.readsAfterTo + 3'h1;
        end
        st_nxt.drBlock = st_r.toArmed
            && st_nxt.readsAfterTo >= `UMFL_RX_READ_LIMIT;
        if (mpuRxWr || fifoReset || !rxToEnhEn) begin
            st_nxt.toArmed = 1'b0;
            st_nxt.readsAfterTo = '0;
            st_nxt.drBlock = 1'b0;
        end

        // MPU told when the receive side drains
        st_nxt.rxEmptyPrev = rxEmpty;
        if (!rxEmpty || mpuPendRd) begin
            st_nxt.mpuRxEmptyIrq = 1'b0;
        end
        if (fifoMode ? (rxEmpty && !st_r.rxEmptyPrev) : rxRdEv) begin
            st_nxt.mpuRxEmptyIrq = 1'b1;
        end

        // In FIFO mode only, host told when the transmit FIFO drains
        st_nxt.txEmptyPrev = txEmpty;
        if (!txEmpty || iirRdEv) begin
            st_nxt.hostTxEmptyIrq = 1'b0;
        end
        if (fifoMode && txEmpty && !st_r.txEmptyPrev) begin
            st_nxt.hostTxEmptyIrq = 1'b1;
        end

        // MPU transmit trigger and timeout
        st_nxt.mpuTxTrigIrq = txCount >= txTrig;
        if (txAccess || txEmpty) begin
            st_nxt.mpuTxToIrq = 1'b0;
        end else if (txToExp) begin
            st_nxt.mpuTxToIrq = 1'b1;
        end

        // Shift buffer: MPU read frees it, the holding byte refills it
        if (mpuTxRd) begin
            st_nxt.tsrFull = 1'b0;
        end
        if (tsrLoad) begin
            st_nxt.tsrFull = 1'b1;
            st_nxt.tsrData = txHead;
        end
        if (fifoReset) begin
            st_nxt.tsrFull = 1'b0;
        end
        st_nxt.mpuTemt = !st_nxt.tsrFull;
        st_nxt.mpuIrq = st_nxt.tsrFull;
        st_nxt.dmaReq = st_nxt.tsrFull;

        // Host transmitter-empty: emulated or written by the MPU
        if (mpuLsrWr) begin
            st_nxt.mpuTemtWr = mpuLsrData[`UMFL_LSR_TRANSMITTER_EMPTY_FLAG];
        end
        if (dblBufEn && charDelayEn) begin
            st_nxt.hostTemt = !st_r.tsrFull && txEmpty && delayExp;
        end else if (dblBufEn) begin
            st_nxt.hostTemt = !st_r.tsrFull && txEmpty;
        end else begin
            st_nxt.hostTemt = st_nxt.mpuTemtWr;
        end

        // Line control mailbox; slave frozen while the MPU reads it
        st_nxt.lcrRdPrev = mpuLcrRd;
        if (lcrWrEv) begin
            st_nxt.lcrMaster = hostLcrData;
            st_nxt.lcrPend = 1'b1;
            if (mpuLcrRd) begin
                st_nxt.lcrWrDuringRd = 1'b1;
            end else begin
                st_nxt.lcrSlave = hostLcrData;
            end
        end
        if (st_r.lcrRdPrev && !mpuLcrRd) begin
            st_nxt.lcrSlave = st_nxt.lcrMaster;
            st_nxt.lcrWrDuringRd = 1'b0;
            if (!st_r.lcrWrDuringRd && !lcrWrEv) begin
                st_nxt.lcrPend = 1'b0;
            end
        end

        // Host view of line status, one cycle behind the FIFOs
        st_nxt.line_status_reg = '0;
        st_nxt.line_status_reg[`UMFL_LSR_DR] = !rxEmpty && !st_nxt.drBlock;
        st_nxt.line_status_reg[`UMFL_LSR_OE] = st_nxt.overrun;
        st_nxt.line_status_reg[`UMFL_LSR_BI:`UMFL_LSR_PE] = st_nxt.errAcc
            | ((fifoMode && !rxEmpty) ? headErr : '0);
        st_nxt.line_status_reg[`UMFL_LSR_HOLDING_EMPTY_FLAG] = txEmpty;
        st_nxt.line_status_reg[`UMFL_LSR_TRANSMITTER_EMPTY_FLAG] = st_nxt.hostTemt;
        st_nxt.line_status_reg[`UMFL_LSR_FERR] = fifoMode && rxFlagged;
        if (!rxEmpty) begin
            st_nxt.rxData = rxHead[`UMFL_DATA_W-1:0]; // Unwritten storage never shown
        end

        // Host FIFO reset drops the flags tied to FIFO contents
        if (fifoReset) begin
            st_nxt.rxToIrq = 1'b0;
            st_nxt.mpuTxToIrq = 1'b0;
            st_nxt.overrun = 1'b0;
            st_nxt.shadow = '0;
        end
    end

    // Synchronous reset clears all but the empty-edge history, which starts at empty; FIFO pointers clear too
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r <= resetState;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lineStatus = st_r.line_status_reg;
    assign rxData = st_r.rxData;
    assign hostRxTrigIrq = st_r.rxTrigIrq;
    assign hostRxTimeoutIrq = st_r.rxToIrq;
    assign hostTxEmptyIrq = st_r.hostTxEmptyIrq;
    assign mpuRxEmptyIrq = st_r.mpuRxEmptyIrq;
    assign mpuTxTrigIrq = st_r.mpuTxTrigIrq;
    assign mpuTxTimeoutIrq = st_r.mpuTxToIrq;
    assign mpuInterruptRequest = st_r.mpuIrq;
    assign mpuDmaRequest = st_r.dmaReq;
    assign mpuTxData = st_r.tsrData;
    assign mpuTemt = st_r.mpuTemt;
    assign lcrValue = st_r.lcrSlave;
    assign lcrPending = st_r.lcrPend;
endmodule // umfl_line_status

// File: umfl_chk.sv
`timescale 1ns/1ps
module umfl_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic mpuRxWr,
    input wire logic mpuLsrWr,
    input wire logic mpuTxRd,
    input wire logic mpuPendRd,
    input wire logic mpuLcrRd,
    input wire logic hostRxRd,
    input wire logic hostLsrRd,
    input wire logic hostIirRd,
    input wire logic hostLcrWr,
    input wire logic [7:0] lineStatus,
    input wire logic hostRxTimeoutIrq,
    input wire logic hostTxEmptyIrq,
    input wire logic mpuRxEmptyIrq,
    input wire logic mpuInterruptRequest,
    input wire logic mpuDmaRequest,
    input wire logic mpuTemt,
    input wire logic [7:0] lcrValue,
    input wire logic lcrPending
);
    logic [1:0] upCnt_r;
    // Outputs need a few edges after reset before relations hold
    always_ff @(posedge clk) begin
        if (!reset_n) upCnt_r <= 2'h0;
        else if (upCnt_r != 2'h3) upCnt_r <= upCnt_r + 2'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n || upCnt_r != 2'h3);
    // Status read with no new error source in the window
    sequence s_lsrRead;
        $rose(hostLsrRd) ##1 (!mpuLsrWr && !mpuRxWr && !hostRxRd) [*6];
    endsequence
    sequence s_iirRead;
        $rose(hostIirRd) ##1 !mpuTxRd [*5];
    endsequence
    property p_lsrClr; s_lsrRead |-> lineStatus[4:1] == 4'h0; endproperty
    a_lsrClr: assert property (p_lsrClr) else $error("status bits kept after read");
    property p_iirClr; s_iirRead |-> !hostTxEmptyIrq; endproperty
    a_iirClr: assert property (p_iirClr) else $error("tx empty irq kept");
    property p_dmaIrq; mpuDmaRequest == mpuInterruptRequest; endproperty
    a_dmaIrq: assert property (p_dmaIrq) else $error("dma and irq differ");
    property p_transmitter_empty_flag; mpuTemt != mpuInterruptRequest; endproperty
    a_transmitter_empty_flag: assert property (p_transmitter_empty_flag) else $error("mpu transmitter_empty_flag wrong");
    property p_drSet; mpuRxWr |-> ##[2:3] lineStatus[0]; endproperty
    a_drSet: assert property (p_drSet) else $error("data ready missing");
    property p_toClr; hostRxTimeoutIrq && mpuRxWr |-> ##[1:3] !hostRxTimeoutIrq; endproperty
    a_toClr: assert property (p_toClr) else $error("timeout irq kept");
    property p_lcrHold; $past(mpuLcrRd) |-> $stable(lcrValue); endproperty
    a_lcrHold: assert property (p_lcrHold) else $error("mailbox changed in read");
    property p_lcrPend; $rose(hostLcrWr) |-> ##[3:5] lcrPending; endproperty
    a_lcrPend: assert property (p_lcrPend) else $error("pending not set");
    property p_pendRd; mpuPendRd |-> ##[1:2] !mpuRxEmptyIrq; endproperty
    a_pendRd: assert property (p_pendRd) else $error("rx empty irq kept");
endmodule // umfl_chk

// File: umfl_host_bus.sv
`timescale 1ns/1ps
module umfl_host_bus (
    input wire logic clk,
    output logic [4:0] strobe,
    output logic [7:0] busData
);
    initial begin
        strobe = 5'h00;
        busData = 8'h00;
    end
    // One access: strobe high two edges, low two, data held past the sync delay
    task automatic access(input int slot, input logic [7:0] value);
        @(posedge clk);
        #1;
        busData = value;
        strobe[slot] = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        strobe[slot] = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        busData = ~value; // Released bus must not look stable
    endtask
endmodule // umfl_host_bus

// File: umfl_line_status_bench.sv
`timescale 1ns/1ps
`include "umfl_defines.svh"
module umfl_line_status_bench;
    logic clk = 1'b0;
    logic serialTick = 1'b0;
    logic [1:0] tickCnt = 2'h0;
    logic reset_n, fifoMode, dblBufEn, charDelayEn, rxToEnhEn, fifoReset;
    logic [1:0] rxTrigSel, txTrigSel;
    logic [7:0] rxToReload, txToReload, charDelayReload, mpuData, busData, v;
    logic mpuRxWr, mpuLsrWr, mpuTxRd, mpuPendRd, mpuLcrRd;
    logic [4:0] hostStb;
    logic [7:0] lineStatus, rxData, mpuTxData, lcrValue;
    logic hostRxTrigIrq, hostRxTimeoutIrq, hostTxEmptyIrq, mpuRxEmptyIrq, mpuTxTrigIrq;
    logic mpuTxTimeoutIrq, mpuInterruptRequest, mpuDmaRequest, mpuTemt, lcrPending;
    logic [7:0] obs [0:5];
    logic [18:0] noteQ [$];
    logic [7:0] rxQ [$];
    logic [7:0] txQ [$];
    int err_count = 0;
    int n_compared = 0;
    int seed;
    int trigTab [4] = '{1, 4, 8, 14};
    event look;
    // 25 MHz clock
    always #20 clk = ~clk;
    // Timer tick one cycle in four, so timeouts span tens of cycles
    always @(posedge clk) begin
        #1;
        tickCnt = tickCnt + 2'h1;
        serialTick = (tickCnt == 2'h3);
    end
    // Output views selected by each note
    assign obs[0] = lineStatus;
    assign obs[1] = rxData;
    assign obs[2] = mpuTxData;
    assign obs[3] = lcrValue;
    assign obs[4] = {hostRxTrigIrq, hostRxTimeoutIrq, hostTxEmptyIrq, mpuRxEmptyIrq,
                     mpuTxTrigIrq, mpuTxTimeoutIrq, mpuInterruptRequest, mpuDmaRequest};
    assign obs[5] = {mpuTemt, lcrPending, 6'h00};
    umfl_line_status dut_u (
        .*,
        .mpuRxData(mpuData),
        .mpuLsrData(mpuData),
        .hostRxRd(hostStb[`UMFL_HS_RXRD]),
        .hostLsrRd(hostStb[`UMFL_HS_LSRRD]),
        .hostIirRd(hostStb[`UMFL_HS_IIRRD]),
        .hostTxWr(hostStb[`UMFL_HS_TXWR]),
        .hostLcrWr(hostStb[`UMFL_HS_LCRWR]),
        .hostTxData(busData),
        .hostLcrData(busData)
    );
    umfl_host_bus host_u (.clk(clk), .strobe(hostStb), .busData(busData));
    task automatic check_val(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic note(input int idx, input logic [7:0] mask, input logic [7:0] exp);
        noteQ.push_back({idx[2:0], mask, exp});
        -> look;
    endtask
    // Oldest note is compared as soon as it is posted
    always @(look) begin
        while (noteQ.size() > 0) begin
            check_val(obs[noteQ[0][18:16]] & noteQ[0][15:8], noteQ[0][7:0]);
            void'(noteQ.pop_front());
        end
    end
    // All drivers act one ns after a rising edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic sig, input logic [7:0] d);
        mpuData = d;
        sig = 1'b1;
        settle(1);
        sig = 1'b0;
        settle(1);
    endtask
    task automatic wait_for(ref logic sig);
        for (int i = 0; i < 400 && sig !== 1'b1; i++) settle(1);
    endtask
    task automatic drain_rx;
        while (rxQ.size() > 0) begin
            note(1, 8'hFF, rxQ.pop_front());
            host_u.access(`UMFL_HS_RXRD, 8'h00);
            settle(2);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Hang guard, far beyond the expected run
    initial begin
        #800000;
        err_count++;
        test_done();
    end
    initial begin
        seed = 97440;
        {reset_n, fifoReset, dblBufEn, charDelayEn, rxToEnhEn} = 5'h00;
        {mpuRxWr, mpuLsrWr, mpuTxRd, mpuPendRd, mpuLcrRd} = 5'h00;
        {rxTrigSel, txTrigSel} = 4'h0;
        fifoMode = 1'b1;
        rxToReload = 8'h03;
        txToReload = 8'h03;
        charDelayReload = 8'h02;
        mpuData = 8'h00;
        repeat (6) @(posedge clk);
        #1;
        reset_n = 1'b1;
        settle(4);
        note(0, 8'hFF, 8'h20);
        note(5, 8'h80, 8'h80);
        note(4, 8'hFF, 8'h00);
        // Every trigger level; flagged first byte; overrun on the last pass
        for (int s = 0; s < 4; s++) begin
            rxTrigSel = 2'(s);
            pulse(mpuLsrWr, 8'h04);
            for (int i = 0; i < ((s == 3) ? 17 : trigTab[s]); i++) begin
                if (i == trigTab[s] - 1) note(4, 8'h80, 8'h00);
                v = 8'($random(seed));
                if (i < 16) rxQ.push_back(v);
                pulse(mpuRxWr, v);
            end
            settle(2);
            note(4, 8'h80, 8'h80);
            note(0, 8'h83, (s == 3) ? 8'h83 : 8'h81);
            drain_rx();
            note(0, 8'h85, 8'h04);
            note(4, 8'h10, 8'h10);
            pulse(mpuPendRd, 8'h00);
            settle(1);
            note(4, 8'h10, 8'h00);
            host_u.access(`UMFL_HS_LSRRD, 8'h00);
            settle(3);
            note(0, 8'h9F, 8'h00);
        end
        // Lone byte below trigger times out; a fresh write reloads
        v = 8'($random(seed));
        rxQ.push_back(v);
        pulse(mpuRxWr, v);
        wait_for(hostRxTimeoutIrq);
        note(4, 8'h40, 8'h40);
        v = 8'($random(seed));
        rxQ.push_back(v);
        pulse(mpuRxWr, v);
        settle(1);
        note(4, 8'h40, 8'h00);
        drain_rx();
        // Paced timeout waits for every byte, then the read budget runs out
        rxToEnhEn = 1'b1;
        for (int i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            rxQ.push_back(v);
            pulse(mpuRxWr, v);
        end
        settle(16);
        note(4, 8'h40, 8'h00);
        wait_for(hostRxTimeoutIrq);
        note(4, 8'h40, 8'h40);
        for (int i = 0; i < 4; i++) begin
            note(1, 8'hFF, rxQ.pop_front());
            host_u.access(`UMFL_HS_RXRD, 8'h00);
        end
        settle(2);
        note(0, 8'h01, 8'h00);
        drain_rx();
        rxToEnhEn = 1'b0;
        // Transmit with double buffering and paced shift loads
        dblBufEn = 1'b1;
        charDelayEn = 1'b1;
        txTrigSel = 2'h1;
        txToReload = 8'h04;
        for (int i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            txQ.push_back(v);
            host_u.access(`UMFL_HS_TXWR, v);
        end
        settle(2);
        note(0, 8'h60, 8'h00);
        note(4, 8'h0B, 8'h0B);
        note(5, 8'h80, 8'h00);
        wait_for(mpuTxTimeoutIrq);
        note(4, 8'h04, 8'h04);
        while (txQ.size() > 0) begin
            wait_for(mpuInterruptRequest);
            note(2, 8'hFF, txQ.pop_front());
            pulse(mpuTxRd, 8'h00);
        end
        settle(16);
        note(0, 8'h60, 8'h60);
        note(4, 8'h23, 8'h20);
        note(5, 8'h80, 8'h80);
        host_u.access(`UMFL_HS_IIRRD, 8'h00);
        settle(2);
        note(4, 8'h20, 8'h00);
        // Mailbox write lands in the master while the MPU reads
        v = 8'($random(seed));
        host_u.access(`UMFL_HS_LCRWR, v);
        settle(2);
        note(3, 8'hFF, v);
        mpuLcrRd = 1'b1;
        settle(2);
        mpuLcrRd = 1'b0;
        settle(2);
        note(5, 8'h40, 8'h00);
        mpuLcrRd = 1'b1;
        host_u.access(`UMFL_HS_LCRWR, ~v);
        settle(2);
        note(3, 8'hFF, v);
        mpuLcrRd = 1'b0;
        settle(3);
        note(3, 8'hFF, ~v);
        note(5, 8'h40, 8'h40);
        settle(1);
        test_done();
    end
endmodule // umfl_line_status_bench
bind umfl_line_status umfl_chk chk_u (.*);
